// ==== testbench/cross_map_byte_move_bench.sv ====
// Purpose: Self-checking bench for the cross-map byte move engine
// Assumes: Inputs change on the falling edge; memory model answers requests
// Notes:   Driver queues expected register results, a monitor compares them
`timescale 1ns/100ps
module cross_map_byte_move_bench;
  typedef struct {logic [15:0] s; logic [15:0] d; logic [15:0] c; logic fin; int lo; int hi;} note_t;
  logic        core_clk_in, sys_rst_in, instr_valid_in, code_data_split_in, irq_pending_in;
  logic [15:0] opcode_in, src_ptr_in, dst_ptr_in, count_in, mem_rdata_in, mem_wdata_out;
  logic [14:0] base_reg_in, mem_addr_out;
  logic        mem_ack_in, instr_ready_out, busy_out, mem_req_out, mem_we_out;
  logic        regs_we_out, done_out, interrupted_out;
  logic [1:0]  mem_map_out, mem_be_out;
  logic [15:0] src_ptr_out, dst_ptr_out, count_out;
  logic [3:0]  mem_wait;
  logic [31:0] seed;
  int          num_errors, samples_checked, cyc, start;
  note_t       notes[$];
  logic [15:0] ops [5];
  byte_move_pkg::map_sel_t smap [5];
  byte_move_pkg::map_sel_t dmap [5];

  cross_map_byte_move dut (.core_clk_in, .sys_rst_in, .instr_valid_in, .opcode_in, .src_ptr_in,
    .dst_ptr_in, .count_in, .code_data_split_in, .base_reg_in, .irq_pending_in, .mem_rdata_in,
    .mem_ack_in, .instr_ready_out, .busy_out, .mem_req_out, .mem_we_out, .mem_map_out,
    .mem_addr_out, .mem_wdata_out, .mem_be_out, .src_ptr_out, .dst_ptr_out, .count_out,
    .regs_we_out, .done_out, .interrupted_out);

  mapped_memory_model mem (.core_clk_in(core_clk_in), .mem_req_in(mem_req_out),
    .mem_we_in(mem_we_out), .mem_map_in(mem_map_out), .mem_addr_in(mem_addr_out),
    .mem_wdata_in(mem_wdata_out), .mem_be_in(mem_be_out), .wait_in(mem_wait),
    .mem_ack_out(mem_ack_in), .mem_rdata_out(mem_rdata_in));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] rd_byte(input int m, input logic [15:0] a);
    logic [15:0] w;
    w = mem.store[m][a[15:1]];
    return a[0] ? w[7:0] : w[15:8];
  endfunction : rd_byte

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got 0x%h exp 0x%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_lat(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("MISMATCH t=%0t latency 0x%h exp 0x%h..0x%h", $time, got, lo, hi);
    end
  endtask : check_lat

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Monitor: each end pulse takes the oldest note
  always @(posedge core_clk_in) begin
    note_t n;
    cyc++;
    if (instr_valid_in && instr_ready_out === 1'b1) start = cyc;
    if (done_out === 1'b1 || interrupted_out === 1'b1) begin
      if (notes.size() == 0) begin
        check_val(count_out, 16'hffff);
      end else begin
        n = notes.pop_front();
        check_val(src_ptr_out, n.s);
        check_val(dst_ptr_out, n.d);
        check_val(count_out, n.c);
        check_val({15'h0000, done_out}, {15'h0000, n.fin});
        if (n.hi > 0) check_lat(cyc - start, n.lo, n.hi);
      end
    end
  end

  task automatic issue(input logic [15:0] op, s, d, n, input logic irq);
    int k;
    k = 0;
    @(negedge core_clk_in);
    while (instr_ready_out !== 1'b1 && k < 5000) begin
      @(negedge core_clk_in);
      k++;
    end
    opcode_in = op;
    src_ptr_in = s;
    dst_ptr_in = d;
    count_in = n;
    irq_pending_in = irq;
    instr_valid_in = 1'b1;
    @(negedge core_clk_in);
    instr_valid_in = 1'b0;
    k = 0;
    while (busy_out !== 1'b0 && k < 5000) begin
      @(negedge core_clk_in);
      k++;
    end
    if (k >= 5000) check_val(16'h0001, 16'h0000);
  endtask : issue

  task automatic run(input int v, input logic [15:0] s, d, n, input logic sp, adj, irq, slow);
    logic [31:0] r;
    logic [15:0] de;
    r = rnd();
    code_data_split_in = sp;
    base_reg_in = 15'h0400 + {3'h0, r[11:0]};
    mem_wait = slow ? r[15:12] : 4'h0;
    de = adj ? d + {base_reg_in, 1'b0} : d;
    if (irq) begin
      notes.push_back('{s + 16'h1, de + 16'h1, n - 16'h1, 1'b0, 0, 0});
      issue(ops[v], s, d, n, 1'b1);
      notes.push_back('{s + n, de + n, 16'h0, 1'b1, 0, 0});
      issue(ops[v], s + 16'h1, de + 16'h1, n - 16'h1, 1'b0);
    end else begin
      notes.push_back('{s + n, de + n, 16'h0, 1'b1, 319 + 91 * n, 330 + 205 * n});
      issue(ops[v], s, d, n, 1'b0);
    end
    for (int i = 0; i < n; i++) begin
      check_val({8'h00, rd_byte(dmap[v], de + 16'(i))}, {8'h00, rd_byte(smap[v], s + 16'(i))});
    end
  endtask : run

  initial begin
    logic [31:0] r;
    logic [15:0] s;
    ops = '{byte_move_pkg::OP_BYTE_MOVE_ALT1_TO_ALT1, byte_move_pkg::OP_BYTE_MOVE_ALT1_TO_ALT2,
            byte_move_pkg::OP_BYTE_MOVE_ALT2_TO_EXEC, byte_move_pkg::OP_BYTE_MOVE_ALT2_TO_ALT1,
            byte_move_pkg::OP_BYTE_MOVE_ALT2_TO_ALT2};
    smap = '{byte_move_pkg::MAP_ALT_ONE, byte_move_pkg::MAP_ALT_ONE, byte_move_pkg::MAP_ALT_TWO,
             byte_move_pkg::MAP_ALT_TWO, byte_move_pkg::MAP_ALT_TWO};
    dmap = '{byte_move_pkg::MAP_ALT_ONE, byte_move_pkg::MAP_ALT_TWO, byte_move_pkg::MAP_EXEC,
             byte_move_pkg::MAP_ALT_ONE, byte_move_pkg::MAP_ALT_TWO};
    seed = 32'h0000_2270;
    {instr_valid_in, code_data_split_in, irq_pending_in} = 3'h0;
    {opcode_in, src_ptr_in, dst_ptr_in, count_in} = 64'h0;
    base_reg_in = 15'h0400;
    mem_wait = 4'h0;
    sys_rst_in = 1'b1;
    repeat (16) @(posedge core_clk_in);
    @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    // Unlisted opcodes must leave the engine idle
    for (int j = 0; j < 2; j++) begin
      opcode_in = j == 0 ? 16'h83da : 16'h03db;
      instr_valid_in = 1'b1;
      repeat (4) @(negedge core_clk_in);
      check_val({15'h0000, busy_out}, 16'h0000);
    end
    instr_valid_in = 1'b0;
    // Every variant, both lanes, bit 15 set on alternate moves, one empty move
    for (int k = 0; k < 11; k++) begin
      r = rnd();
      s = {k[0], r[14:4], 1'b0, r[2:0]};
      run(k % 5, s, (s ^ 16'h4000) ^ {15'h0, r[5]}, k == 7 ? 16'h0 : {13'h0, r[18:16]} + 16'h1,
          1'b0, 1'b0, 1'b0, k[1]);
    end
    // Split mode: exec destination inside and outside the base window, alternate map
    r = rnd();
    run(2, {2'h1, r[13:0]}, {5'h00, 1'b1, r[19:11], 1'b1}, 16'h5, 1'b1, 1'b1, 1'b0, 1'b0);
    run(0, {2'h1, r[13:0]}, 16'h0203, 16'h4, 1'b1, 1'b0, 1'b0, 1'b1);
    run(2, 16'h0100, 16'h9001, 16'h3, 1'b1, 1'b0, 1'b0, 1'b0);
    // Interrupt after the first byte, then resume from the written-back values
    run(1, 16'h2345, 16'h6788, 16'h4, 1'b0, 1'b0, 1'b1, 1'b1);
    run(4, 16'h1001, 16'h3002, 16'h3, 1'b1, 1'b0, 1'b1, 1'b0);
    repeat (4) @(negedge core_clk_in);
    check_val(16'(notes.size()), 16'h0000);
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge core_clk_in);
    num_errors++;
    finish_test();
  end
endmodule : cross_map_byte_move_bench

// ==== testbench/mapped_memory_model.sv ====
// Purpose: Mapped main memory behind the byte move engine, four maps of 32768 words
// Assumes: Request held until ack; ack is a one-cycle pulse after wait_in idle cycles
// Notes:   Read data toggles outside the ack cycle so stale values never match
`timescale 1ns/100ps
module mapped_memory_model (
  input  wire logic        core_clk_in,
  input  wire logic        mem_req_in,
  input  wire logic        mem_we_in,
  input  wire logic [1:0]  mem_map_in,
  input  wire logic [14:0] mem_addr_in,
  input  wire logic [15:0] mem_wdata_in,
  input  wire logic [1:0]  mem_be_in,
  input  wire logic [3:0]  wait_in,
  output logic             mem_ack_out,
  output logic [15:0]      mem_rdata_out
);
  logic [15:0] store [4][32768];
  logic [3:0]  wait_r;

  initial begin
    mem_ack_out = 1'b0;
    mem_rdata_out = 16'h5a5a;
    wait_r = 4'h0;
    for (int m = 0; m < 4; m++) begin
      for (int w = 0; w < 32768; w++) begin
        store[m][w] = 16'(w * 7 + m * 16'h1357);
      end
    end
  end

  // Prompt or slow answer, one access per request
  always @(posedge core_clk_in) begin
    mem_rdata_out <= ~mem_rdata_out;
    if (mem_ack_out) begin
      mem_ack_out <= 1'b0;
      wait_r <= 4'h0;
      if (mem_we_in && mem_be_in[1]) store[mem_map_in][mem_addr_in][15:8] <= mem_wdata_in[15:8];
      if (mem_we_in && mem_be_in[0]) store[mem_map_in][mem_addr_in][7:0] <= mem_wdata_in[7:0];
    end else if (mem_req_in) begin
      if (wait_r >= wait_in) begin
        mem_ack_out <= 1'b1;
        if (!mem_we_in) mem_rdata_out <= store[mem_map_in][mem_addr_in];
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule : mapped_memory_model

// ==== verilog/byte_lane_unit.sv ====
// Purpose: Splits byte addresses into word address and byte lane
// Assumes: Even byte address is the high half of the word
// Notes:   Pure combinational logic
`timescale 1ns/100ps
module byte_lane_unit (
  lane_if.lane lane
);

  always_comb begin
    lane.src_word = lane.src_byte[15:1];
    lane.dst_word = lane.dst_byte[15:1];
    if (lane.src_byte[0]) begin
      lane.rd_byte = lane.rd_word[7:0];
    end else begin
      lane.rd_byte = lane.rd_word[15:8];
    end
    lane.wr_word = {lane.wr_byte, lane.wr_byte};
    lane.wr_be   = lane.dst_byte[0] ? 2'h1 : 2'h2;
  end

endmodule : byte_lane_unit

// ==== verilog/byte_move_pkg.sv ====
// Purpose: Shared constants and types for the cross-map byte move engine
// Assumes: 100 MHz processor clock, 16-bit byte addresses, 15-bit word addresses
// Notes:   Opcodes, map codes, address window and timing counts live here
package byte_move_pkg;

  // Map selectors presented to the mapping hardware
  typedef enum logic [1:0] {
    MAP_EXEC    = 2'h0,
    MAP_ALT_ONE = 2'h1,
    MAP_ALT_TWO = 2'h2
  } map_sel_t;

  // Engine states, Gray coded along the straight path from ST_IDLE to ST_DONE
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_CHECK    = 3'h1,
    ST_OVERHEAD = 3'h3,
    ST_READ     = 3'h2,
    ST_WRITE    = 3'h6,
    ST_PACE     = 3'h7,
    ST_DONE     = 3'h5
  } move_state_t;

  // Opcodes of the byte move group
  localparam logic [15:0] OP_BYTE_MOVE_ALT1_TO_ALT1 = 16'h83db;
  localparam logic [15:0] OP_BYTE_MOVE_ALT1_TO_ALT2 = 16'h83dc;
  localparam logic [15:0] OP_BYTE_MOVE_ALT2_TO_EXEC = 16'h83dd;
  localparam logic [15:0] OP_BYTE_MOVE_ALT2_TO_ALT1 = 16'h83de;
  localparam logic [15:0] OP_BYTE_MOVE_ALT2_TO_ALT2 = 16'h83df;

  // Address spaces
  localparam int          LOGICAL_SPACE_WORDS = 32768;
  localparam int          CODE_SPACE_WORDS    = 4194304;
  localparam int          WORD_ADDR_W         = $clog2(LOGICAL_SPACE_WORDS);
  localparam logic [14:0] BASE_LO_WORD        = 15'h0002;
  localparam logic [14:0] BASE_HI_WORD        = 15'h03ff;

  // Reset values
  localparam logic [15:0] RST_PTR   = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;

  // Timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int OVERHEAD_NS         = 3190;
  localparam int BYTE_MIN_NS         = 910;
  localparam int BYTE_MAX_NS         = 2050;
  localparam int REFRESH_STRETCH_PCT = 3;
  localparam int OVERHEAD_CYC = (OVERHEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_MIN_CYC = (BYTE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_MAX_CYC = BYTE_MAX_NS / CLK_PERIOD_NS;
  localparam logic [8:0] OVERHEAD_LAST = 9'(OVERHEAD_CYC - 1);
  localparam logic [7:0] BYTE_MIN_LAST = 8'(BYTE_MIN_CYC - 1);

endpackage : byte_move_pkg

// ==== verilog/cross_map_byte_move.sv ====
// Purpose: Microcoded cross-map byte block move engine
// Assumes: Memory answers each request with a one-cycle ack on the same clock
// Notes:   Progress is written back after every byte so a move can resume
`timescale 1ns/100ps
module cross_map_byte_move (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        instr_valid_in,
  input  wire logic [15:0] opcode_in,
  input  wire logic [15:0] src_ptr_in,
  input  wire logic [15:0] dst_ptr_in,
  input  wire logic [15:0] count_in,
  input  wire logic        code_data_split_in,
  input  wire logic [14:0] base_reg_in,
  input  wire logic        irq_pending_in,
  input  wire logic [15:0] mem_rdata_in,
  input  wire logic        mem_ack_in,
  output logic             instr_ready_out,
  output logic             busy_out,
  output logic             mem_req_out,
  output logic             mem_we_out,
  output logic [1:0]       mem_map_out,
  output logic [14:0]      mem_addr_out,
  output logic [15:0]      mem_wdata_out,
  output logic [1:0]       mem_be_out,
  output logic [15:0]      src_ptr_out,
  output logic [15:0]      dst_ptr_out,
  output logic [15:0]      count_out,
  output logic             regs_we_out,
  output logic             done_out,
  output logic             interrupted_out
);
  byte_move_pkg::move_state_t state_r;
  byte_move_pkg::map_sel_t    smap_r;
  byte_move_pkg::map_sel_t    dmap_r;
  byte_move_pkg::map_sel_t    dec_smap;
  byte_move_pkg::map_sel_t    dec_dmap;
  logic                       dec_ok;
  logic                       cds_r;
  logic [14:0]                base_r;
  logic [15:0]                src_r;
  logic [15:0]                dst_r;
  logic [15:0]                cnt_r;
  logic [7:0]                 byte_r;
  logic [8:0]                 ovh_cnt_r;
  logic [7:0]                 byte_cnt_r;
  logic                       mem_req_r;
  logic                       mem_we_r;
  logic [1:0]                 mem_map_r;
  logic [14:0]                mem_addr_r;
  logic [15:0]                mem_wdata_r;
  logic [1:0]                 mem_be_r;
  logic                       regs_we_r;
  logic                       done_r;
  logic                       intr_r;
  logic                       xfer_done;
  logic                       base_hit;
  logic                       pace_met;
  logic                       ready_r;
  logic                       busy_r;
  lane_if lane ();
  byte_lane_unit u_lane (
    .lane (lane)
  );
  assign lane.src_byte = src_r;
  assign lane.dst_byte = dst_r;
  assign lane.rd_word  = mem_rdata_in;
  assign lane.wr_byte  = byte_r;
  assign xfer_done = mem_req_r && mem_ack_in;
  assign pace_met  = byte_cnt_r >= byte_move_pkg::BYTE_MIN_LAST;
  // Exec destination word inside the base-relative window
  assign base_hit  = cds_r && (dmap_r == byte_move_pkg::MAP_EXEC)
                     && (dst_r[15:1] >= byte_move_pkg::BASE_LO_WORD)
                     && (dst_r[15:1] <= byte_move_pkg::BASE_HI_WORD);
  // Opcode decode to source and destination maps
  always_comb begin
    dec_ok   = 1'b1;
    dec_smap = byte_move_pkg::MAP_ALT_ONE;
    dec_dmap = byte_move_pkg::MAP_ALT_ONE;
    case (opcode_in)
      byte_move_pkg::OP_BYTE_MOVE_ALT1_TO_ALT1: begin
        dec_smap = byte_move_pkg::MAP_ALT_ONE;
        dec_dmap = byte_move_pkg::MAP_ALT_ONE;
      end
      byte_move_pkg::OP_BYTE_MOVE_ALT1_TO_ALT2: begin
        dec_smap = byte_move_pkg::MAP_ALT_ONE;
        dec_dmap = byte_move_pkg::MAP_ALT_TWO;
      end
      byte_move_pkg::OP_BYTE_MOVE_ALT2_TO_EXEC: begin
        dec_smap = byte_move_pkg::MAP_ALT_TWO;
        dec_dmap = byte_move_pkg::MAP_EXEC;
      end
      byte_move_pkg::OP_BYTE_MOVE_ALT2_TO_ALT1: begin
        dec_smap = byte_move_pkg::MAP_ALT_TWO;
        dec_dmap = byte_move_pkg::MAP_ALT_ONE;
      end
      byte_move_pkg::OP_BYTE_MOVE_ALT2_TO_ALT2: begin
        dec_smap = byte_move_pkg::MAP_ALT_TWO;
        dec_dmap = byte_move_pkg::MAP_ALT_TWO;
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_r <= byte_move_pkg::ST_IDLE;
      ready_r <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      case (state_r)
        byte_move_pkg::ST_IDLE: begin
          if (instr_valid_in && dec_ok) begin
            state_r <= byte_move_pkg::ST_CHECK;
            ready_r <= 1'b0;
            busy_r  <= 1'b1;
          end
        end
        byte_move_pkg::ST_CHECK: begin
          state_r <= byte_move_pkg::ST_OVERHEAD;
        end
        byte_move_pkg::ST_OVERHEAD: begin
          if (ovh_cnt_r == byte_move_pkg::OVERHEAD_LAST) begin
            state_r <= (cnt_r == 16'h0000) ? byte_move_pkg::ST_DONE
                                           : byte_move_pkg::ST_READ;
          end
        end
        byte_move_pkg::ST_READ: begin
          if (xfer_done) begin
            state_r <= byte_move_pkg::ST_WRITE;
          end
        end
        byte_move_pkg::ST_WRITE: begin
          if (xfer_done) begin
            state_r <= byte_move_pkg::ST_PACE;
          end
        end
        byte_move_pkg::ST_PACE: begin
          if (pace_met) begin
            if (cnt_r == 16'h0000 || irq_pending_in) begin
              state_r <= byte_move_pkg::ST_DONE;
            end else begin
              state_r <= byte_move_pkg::ST_READ;
            end
          end
        end
        byte_move_pkg::ST_DONE: begin
          state_r <= byte_move_pkg::ST_IDLE;
          ready_r <= 1'b1;
          busy_r  <= 1'b0;
        end
        default: begin
          state_r <= byte_move_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // Operand registers: maps, pointers and count
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      smap_r <= byte_move_pkg::MAP_EXEC;
      dmap_r <= byte_move_pkg::MAP_EXEC;
      cds_r  <= 1'b0;
      base_r <= 15'h0000;
      src_r  <= byte_move_pkg::RST_PTR;
      dst_r  <= byte_move_pkg::RST_PTR;
      cnt_r  <= byte_move_pkg::RST_COUNT;
    end else if (state_r == byte_move_pkg::ST_IDLE && instr_valid_in && dec_ok) begin
      smap_r <= dec_smap;
      dmap_r <= dec_dmap;
      cds_r  <= code_data_split_in;
      base_r <= base_reg_in;
      src_r  <= src_ptr_in;
      dst_r  <= dst_ptr_in;
      cnt_r  <= count_in;
    end else if (state_r == byte_move_pkg::ST_CHECK && base_hit) begin
      dst_r <= dst_r + {base_r, 1'b0};
    end else if (state_r == byte_move_pkg::ST_WRITE && xfer_done) begin
      src_r <= src_r + 16'h0001;
      dst_r <= dst_r + 16'h0001;
      cnt_r <= cnt_r - 16'h0001;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      byte_r <= byte_move_pkg::RST_BYTE;
    end else if (state_r == byte_move_pkg::ST_READ && xfer_done) begin
      byte_r <= lane.rd_byte;
    end
  end
  // Overhead and per-byte pacing counters
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || state_r != byte_move_pkg::ST_OVERHEAD) begin
      ovh_cnt_r <= 9'h000;
    end else begin
      ovh_cnt_r <= ovh_cnt_r + 9'h001;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || !(state_r == byte_move_pkg::ST_READ
        || state_r == byte_move_pkg::ST_WRITE || state_r == byte_move_pkg::ST_PACE)) begin
      byte_cnt_r <= 8'h00;
    end else if (state_r == byte_move_pkg::ST_PACE && pace_met) begin
      byte_cnt_r <= 8'h00;
    end else if (byte_cnt_r != 8'hff) begin
      byte_cnt_r <= byte_cnt_r + 8'h01;
    end
  end
  // Memory request port, held until acknowledged
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mem_req_r   <= 1'b0;
      mem_we_r    <= 1'b0;
      mem_map_r   <= 2'h0;
      mem_addr_r  <= 15'h0000;
      mem_wdata_r <= 16'h0000;
      mem_be_r    <= 2'h0;
    end else begin
      mem_req_r <= (state_r == byte_move_pkg::ST_READ || state_r == byte_move_pkg::ST_WRITE)
                   && !xfer_done;
      if (!mem_req_r) begin
        if (state_r == byte_move_pkg::ST_WRITE) begin
          mem_we_r    <= 1'b1;
          mem_map_r   <= dmap_r;
          mem_addr_r  <= lane.dst_word;
          mem_wdata_r <= lane.wr_word;
          mem_be_r    <= lane.wr_be;
        end else begin
          mem_we_r    <= 1'b0;
          mem_map_r   <= smap_r;
          mem_addr_r  <= lane.src_word;
          mem_wdata_r <= 16'h0000;
          mem_be_r    <= 2'h3;
        end
      end
    end
  end
  // Register write-back and completion pulses
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      regs_we_r <= 1'b0;
      done_r    <= 1'b0;
      intr_r    <= 1'b0;
    end else begin
      regs_we_r <= (state_r == byte_move_pkg::ST_WRITE && xfer_done)
                   || (state_r == byte_move_pkg::ST_CHECK);
      done_r    <= state_r == byte_move_pkg::ST_DONE && cnt_r == 16'h0000;
      intr_r    <= state_r == byte_move_pkg::ST_DONE && cnt_r != 16'h0000;
    end
  end
  assign instr_ready_out = ready_r;
  assign busy_out        = busy_r;
  assign mem_req_out     = mem_req_r;
  assign mem_we_out      = mem_we_r;
  assign mem_map_out     = mem_map_r;
  assign mem_addr_out    = mem_addr_r;
  assign mem_wdata_out   = mem_wdata_r;
  assign mem_be_out      = mem_be_r;
  assign src_ptr_out     = src_r;
  assign dst_ptr_out     = dst_r;
  assign count_out       = cnt_r;
  assign regs_we_out     = regs_we_r;
  assign done_out        = done_r;
  assign interrupted_out = intr_r;
  a_done_count_zero: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    done_out |-> count_out == 16'h0000)
    else $error("count not zero at completion");
  a_overhead_wait: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    ($past(state_r) == byte_move_pkg::ST_OVERHEAD && state_r != byte_move_pkg::ST_OVERHEAD)
    |-> $past(ovh_cnt_r) == byte_move_pkg::OVERHEAD_LAST)
    else $error("overhead period wrong");
  a_byte_pace_min: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    ($past(state_r) == byte_move_pkg::ST_PACE && state_r != byte_move_pkg::ST_PACE)
    |-> $past(byte_cnt_r) >= byte_move_pkg::BYTE_MIN_LAST)
    else $error("byte paced too fast");
  a_ptr_advance: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state_r == byte_move_pkg::ST_WRITE && xfer_done)
    |=> src_ptr_out == $past(src_ptr_out) + 16'h0001
        && dst_ptr_out == $past(dst_ptr_out) + 16'h0001
        && count_out == $past(count_out) - 16'h0001 && regs_we_out)
    else $error("pointers did not advance");
  a_base_adjust: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state_r == byte_move_pkg::ST_CHECK && cds_r && dmap_r == byte_move_pkg::MAP_EXEC
     && dst_r[15:1] >= 15'h0002 && dst_r[15:1] <= 15'h03ff)
    |=> dst_ptr_out == $past(dst_r) + {$past(base_r), 1'b0})
    else $error("base adjust missing");
  a_alt_no_adjust: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state_r == byte_move_pkg::ST_CHECK && dmap_r != byte_move_pkg::MAP_EXEC)
    |=> $stable(dst_ptr_out))
    else $error("alternate map destination adjusted");
  a_read_lane: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (mem_req_out && !mem_we_out)
    |-> mem_addr_out == src_r[15:1] && mem_map_out == smap_r)
    else $error("read address or map wrong");
  a_write_lane: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (mem_req_out && mem_we_out)
    |-> mem_addr_out == dst_r[15:1] && mem_map_out == dmap_r
        && mem_be_out == (dst_r[0] ? 2'h1 : 2'h2))
    else $error("write address, map or lane wrong");
  a_decode_alt12: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (instr_ready_out && instr_valid_in && opcode_in == 16'h83dc)
    |=> smap_r == byte_move_pkg::MAP_ALT_ONE && dmap_r == byte_move_pkg::MAP_ALT_TWO)
    else $error("alt one to alt two decode wrong");
  a_irq_stop: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state_r == byte_move_pkg::ST_PACE && pace_met && irq_pending_in)
    |=> state_r == byte_move_pkg::ST_DONE ##1 (done_out || interrupted_out))
    else $error("interrupt not honoured");
  c_zero_count: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $past(state_r) == byte_move_pkg::ST_OVERHEAD && state_r == byte_move_pkg::ST_DONE);
  c_interrupted: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    interrupted_out);
  c_exec_adjust: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == byte_move_pkg::ST_CHECK && base_hit);
  c_full_move: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    done_out && $past(state_r, 2) == byte_move_pkg::ST_PACE);
endmodule : cross_map_byte_move

// ==== verilog/lane_if.sv ====
// Purpose: Carries byte addresses and data between engine and lane unit
// Assumes: Combinational lane unit
// Notes:   core modport drives addresses and data, lane modport answers
`timescale 1ns/100ps
interface lane_if;
  logic [15:0] src_byte;
  logic [15:0] dst_byte;
  logic [15:0] rd_word;
  logic [7:0]  wr_byte;
  logic [14:0] src_word;
  logic [14:0] dst_word;
  logic [7:0]  rd_byte;
  logic [15:0] wr_word;
  logic [1:0]  wr_be;

  modport core (output src_byte, dst_byte, rd_word, wr_byte,
                input  src_word, dst_word, rd_byte, wr_word, wr_be);
  modport lane (input  src_byte, dst_byte, rd_word, wr_byte,
                output src_word, dst_word, rd_byte, wr_word, wr_be);
endinterface : lane_if
